//--- inc/sup_pkg.sv
//==========================================================
package sup_pkg;

    localparam int CLK_MHZ = 25;

    // Filter, blanking and autorecovery times in microseconds
    localparam int BO_FILT_US   = 20;
    localparam int OVP_FILT_US  = 10;
    localparam int OTP_FILT_US  = 20;
    localparam int OTP_BLANK_US = 100;
    localparam int AR_TIME_US   = 1000;

    localparam logic [15:0] BO_FILT_CYC   = 16'(BO_FILT_US * CLK_MHZ);
    localparam logic [15:0] OVP_FILT_CYC  = 16'(OVP_FILT_US * CLK_MHZ);
    localparam logic [15:0] OTP_FILT_CYC  = 16'(OTP_FILT_US * CLK_MHZ);
    localparam logic [15:0] OTP_BLANK_CYC = 16'(OTP_BLANK_US * CLK_MHZ);
    localparam logic [15:0] AR_TIME_CYC   = 16'(AR_TIME_US * CLK_MHZ);

    // Register offsets
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_MASK   = 8'h08;
    localparam logic [7:0] A_LIVE   = 8'h0c;
    localparam logic [7:0] A_BOLEN  = 8'h10;
    localparam logic [7:0] A_OVPLEN = 8'h14;
    localparam logic [7:0] A_OTPLEN = 8'h18;
    localparam logic [7:0] A_BLKLEN = 8'h1c;
    localparam logic [7:0] A_ARLEN  = 8'h20;

    // Control fields
    localparam int C_OVP_LATCH = 0;
    localparam int C_OTP_LATCH = 1;
    localparam int C_ACTIVE_ON = 2;
    localparam logic [2:0] CTRL_RST = 3'h3;

    // Event bits of status and mask
    localparam int E_BG_RISE = 0;
    localparam int E_BG_FALL = 1;
    localparam int E_OVP     = 2;
    localparam int E_OTP     = 3;
    localparam int E_AR_END  = 4;
    localparam int E_OFF_IN  = 5;
    localparam logic [5:0] MASK_RST = 6'h00;

    typedef enum logic [1:0] {
        ST_RESET   = 2'b00,
        ST_RUN     = 2'b01,
        ST_AUTOREC = 2'b11,
        ST_LATCH   = 2'b10
    } st_t;

    // Synchronised analogue flags
    typedef struct packed {
        logic vcc_on;
        logic vcc_off;
        logic vcc_rst;
        logic bo;
        logic ovp;
        logic otp;
        logic skip_in;
        logic skip_out;
        logic rem_off;
        logic rem_on;
        logic fb_off;
        logic fb_resume;
    } flags_t;

endpackage

//--- rtl/bo_ovp_supervisor.sv
`timescale 1ns/1ps
module bo_ovp_supervisor
    import sup_pkg::*;
#(
    parameter logic [15:0] AR_CYCLES = AR_TIME_CYC
)
(
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        arst_n_in,
    // Supply and comparator flags, asynchronous
    input  wire logic        vcc_above_on_in,
    input  wire logic        vcc_above_off_in,
    input  wire logic        vcc_above_reset_in,
    input  wire logic        bo_cmp_in,
    input  wire logic        ovp_cmp_in,
    input  wire logic        otp_cmp_in,
    input  wire logic        skip_entry_in,
    input  wire logic        skip_exit_in,
    input  wire logic        remote_off_in,
    input  wire logic        remote_on_in,
    input  wire logic        fb_offmode_in,
    input  wire logic        fb_resume_in,
    // Register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wr_data_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rd_data_out,
    output logic             irq_out,
    // Analogue and driver controls
    output logic             bulk_hyst_sink_out,
    output logic             bulk_discharge_out,
    output logic             thermistor_bias_out,
    output logic             thermistor_bias_boosted_out,
    output logic             prot_monitor_on_out,
    output logic             bulk_good_out,
    output logic             drive_enable_out
);

    //======================================================
    // Reset release
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    //======================================================
    // Flag synchronisers
    logic [11:0] sync1_q;
    logic [11:0] sync2_q;
    flags_t      f;

    always_ff @(posedge ref_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            sync1_q <= 12'h000;
            sync2_q <= 12'h000;
        end
        else
        begin
            sync1_q <= {vcc_above_on_in, vcc_above_off_in,
                        vcc_above_reset_in, bo_cmp_in, ovp_cmp_in,
                        otp_cmp_in, skip_entry_in, skip_exit_in,
                        remote_off_in, remote_on_in, fb_offmode_in,
                        fb_resume_in};
            sync2_q <= sync1_q;
        end
    end

    assign f = flags_t'(sync2_q);

    function automatic logic [15:0] filt_next(
        input logic [15:0] cnt,
        input logic        cond,
        input logic [15:0] len
    );
        if (!cond)
            filt_next = 16'h0000;
        else if (cnt >= len)
            filt_next = len;
        else
            filt_next = cnt + 16'h0001;
    endfunction

    //======================================================
    // Registers
    logic [2:0]  ctrl_q;
    logic [5:0]  status_q;
    logic [5:0]  status_d;
    logic [5:0]  mask_q;
    logic [5:0]  ev;
    logic [15:0] bo_len_q;
    logic [15:0] ovp_len_q;
    logic [15:0] otp_len_q;
    logic [15:0] blk_len_q;
    logic [15:0] ar_len_q;
    logic [31:0] live;

    always_ff @(posedge ref_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ctrl_q    <= CTRL_RST;
            mask_q    <= MASK_RST;
            bo_len_q  <= BO_FILT_CYC;
            ovp_len_q <= OVP_FILT_CYC;
            otp_len_q <= OTP_FILT_CYC;
            blk_len_q <= OTP_BLANK_CYC;
            ar_len_q  <= AR_CYCLES;
        end
        else if (wr_in)
        begin
            case (addr_in)
                A_CTRL:   ctrl_q    <= wr_data_in[2:0];
                A_MASK:   mask_q    <= wr_data_in[5:0];
                A_BOLEN:  bo_len_q  <= wr_data_in[15:0];
                A_OVPLEN: ovp_len_q <= wr_data_in[15:0];
                A_OTPLEN: otp_len_q <= wr_data_in[15:0];
                A_BLKLEN: blk_len_q <= wr_data_in[15:0];
                A_ARLEN:  ar_len_q  <= wr_data_in[15:0];
                default:  ;
            endcase
        end
    end

    // Sticky events, write one clears, set wins
    always_comb
    begin
        status_d = status_q;
        if (wr_in && addr_in == A_STATUS)
            status_d = status_q & ~wr_data_in[5:0];
        status_d = status_d | ev;
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            status_q <= 6'h00;
            irq_out  <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            irq_out  <= |(status_d & mask_q);
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
            rd_data_out <= 32'h0000_0000;
        else if (rd_in)
        begin
            case (addr_in)
                A_CTRL:   rd_data_out <= {29'h0, ctrl_q};
                A_STATUS: rd_data_out <= {26'h0, status_q};
                A_MASK:   rd_data_out <= {26'h0, mask_q};
                A_LIVE:   rd_data_out <= live;
                A_BOLEN:  rd_data_out <= {16'h0, bo_len_q};
                A_OVPLEN: rd_data_out <= {16'h0, ovp_len_q};
                A_OTPLEN: rd_data_out <= {16'h0, otp_len_q};
                A_BLKLEN: rd_data_out <= {16'h0, blk_len_q};
                A_ARLEN:  rd_data_out <= {16'h0, ar_len_q};
                default:  rd_data_out <= 32'h0000_0000;
            endcase
        end
        else
            rd_data_out <= 32'h0000_0000;
    end

    //======================================================
    // Brown-out filter
    logic [15:0] bo_cnt_q;
    logic        bulk_good_q;
    logic        bo_flip;
    logic        bg_d;

    assign bo_flip = (f.bo != bulk_good_q) && (bo_cnt_q >= bo_len_q);
    assign bg_d    = bo_flip ? ~bulk_good_q : bulk_good_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            bo_cnt_q    <= 16'h0000;
            bulk_good_q <= 1'b0;
        end
        else
        begin
            bo_cnt_q    <= bo_flip ? 16'h0000 :
                           filt_next(bo_cnt_q, f.bo != bulk_good_q,
                                     bo_len_q);
            bulk_good_q <= bg_d;
        end
    end

    //======================================================
    // Skip and off-mode tracking
    logic skip_q;
    logic off_q;
    logic off_set;
    logic off_clr;

    assign off_set = ctrl_q[C_ACTIVE_ON] ? f.rem_off
                                         : (f.fb_off && !f.vcc_off);
    assign off_clr = ctrl_q[C_ACTIVE_ON] ? f.rem_on : f.fb_resume;

    always_ff @(posedge ref_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            skip_q <= 1'b0;
            off_q  <= 1'b0;
        end
        else
        begin
            if (!skip_q && f.skip_in)
                skip_q <= 1'b1;
            else if (skip_q && f.skip_out)
                skip_q <= 1'b0;
            if (!off_q && off_set)
                off_q <= 1'b1;
            else if (off_q && off_clr)
                off_q <= 1'b0;
        end
    end

    //======================================================
    // Protection filters and state
    st_t         st_q;
    st_t         st_d;
    logic [15:0] ovp_cnt_q;
    logic [15:0] otp_cnt_q;
    logic [15:0] blk_cnt_q;
    logic [15:0] ar_cnt_q;
    logic [1:0]  src_q;
    logic        mon_q;
    logic        mon_set;
    logic        mon_clr;
    logic        blanking;
    logic        ovp_cond;
    logic        otp_cond;
    logic        ovp_trip;
    logic        otp_trip;
    logic        trip_latch;
    logic        ar_end;
    logic        vcc_on_ev;

    assign blanking = mon_q && (blk_cnt_q < blk_len_q);
    assign ovp_cond = f.ovp && mon_q && st_q == ST_RUN;
    assign otp_cond = f.otp && mon_q && !blanking && st_q == ST_RUN;
    assign ovp_trip = ovp_cond && ovp_cnt_q >= ovp_len_q;
    assign otp_trip = otp_cond && otp_cnt_q >= otp_len_q;
    assign trip_latch = (ovp_trip && ctrl_q[C_OVP_LATCH]) ||
                        (otp_trip && ctrl_q[C_OTP_LATCH]);
    assign ar_end    = st_q == ST_AUTOREC && ar_cnt_q >= ar_len_q;
    assign vcc_on_ev = st_q == ST_RESET && f.vcc_on;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_RESET:
                if (f.vcc_on)
                    st_d = ST_RUN;
            ST_RUN:
                if (ovp_trip || otp_trip)
                    st_d = trip_latch ? ST_LATCH : ST_AUTOREC;
                else if (!f.vcc_rst)
                    st_d = ST_RESET;
            ST_AUTOREC:
                if (ar_end)
                    st_d = ST_RUN;
                else if (!f.vcc_rst)
                    st_d = ST_RESET;
            ST_LATCH:
                if (!f.vcc_rst)
                    st_d = ST_RESET;
            default:
                st_d = ST_RESET;
        endcase
    end

    assign mon_set = vcc_on_ev || (bo_flip && !bulk_good_q) || ar_end ||
                     (skip_q && f.skip_out) || (off_q && off_clr);
    // bias off on supply, brown-out, fault
    // bias off on skip and off-mode entry
    assign mon_clr = !f.vcc_off || (bo_flip && bulk_good_q) ||
                     ovp_trip || otp_trip ||
                     (st_q != ST_RUN && !ar_end && !vcc_on_ev) ||
                     (!skip_q && f.skip_in) || (!off_q && off_set);

    always_ff @(posedge ref_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            st_q      <= ST_RESET;
            mon_q     <= 1'b0;
            ovp_cnt_q <= 16'h0000;
            otp_cnt_q <= 16'h0000;
            blk_cnt_q <= 16'h0000;
            ar_cnt_q  <= 16'h0000;
        end
        else
        begin
            st_q      <= st_d;
            mon_q     <= mon_clr ? 1'b0 : (mon_set ? 1'b1 : mon_q);
            ovp_cnt_q <= filt_next(ovp_cnt_q, ovp_cond, ovp_len_q);
            otp_cnt_q <= filt_next(otp_cnt_q, otp_cond, otp_len_q);
            blk_cnt_q <= filt_next(blk_cnt_q, mon_q, blk_len_q);
            ar_cnt_q  <= filt_next(ar_cnt_q, st_q == ST_AUTOREC &&
                                   !ar_end, ar_len_q);
        end
    end

    // trip source held until the state next returns to run or goes to reset
    always_ff @(posedge ref_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
            src_q <= 2'b00;
        else if (ovp_trip || otp_trip)
            src_q <= {otp_trip, ovp_trip};
        else if (st_d == ST_RUN && st_q != ST_RUN || st_d == ST_RESET)
            src_q <= 2'b00;
    end

    assign ev = {!off_q && off_set, ar_end, otp_trip, ovp_trip,
                 bo_flip && bulk_good_q, bo_flip && !bulk_good_q};
    assign live = {24'h0, src_q, off_q, skip_q, mon_q, bulk_good_q,
                   st_q};

    //======================================================
    // Output stage
    always_ff @(posedge ref_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            bulk_discharge_out          <= 1'b1;
            bulk_hyst_sink_out          <= 1'b0;
            thermistor_bias_boosted_out <= 1'b0;
            drive_enable_out            <= 1'b0;
        end
        else
        begin
            bulk_discharge_out <= st_d == ST_RESET;
            bulk_hyst_sink_out <= st_d != ST_RESET && !bg_d;
            thermistor_bias_boosted_out <= blanking;
            drive_enable_out <= st_d == ST_RUN && bg_d && f.vcc_off &&
                                !skip_q && !off_q &&
                                !ovp_trip && !otp_trip;
        end
    end

    assign thermistor_bias_out = mon_q;
    assign prot_monitor_on_out = mon_q;
    assign bulk_good_out       = bulk_good_q;

    //======================================================
    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_q);

    sequence s_trip;
        ovp_trip || otp_trip;
    endsequence

    sequence s_latch_left;
        st_q == ST_LATCH ##1 st_q != ST_LATCH;
    endsequence

    chk_sink_bg_high:
        assert property (bulk_good_q |-> !bulk_hyst_sink_out)
        else $error("sink on while bulk good");
    chk_discharge_start:
        assert property (st_q == ST_RESET |-> bulk_discharge_out)
        else $error("discharge off in startup");
    chk_release_step:
        assert property ($fell(bulk_discharge_out) |->
                         bulk_hyst_sink_out == !bulk_good_q)
        else $error("sink not enabled with release");
    chk_drive_bo:
        assert property (drive_enable_out |-> $past(bg_d))
        else $error("drive without bulk good");
    chk_bo_filter:
        assert property ($changed(bulk_good_q) |->
                         $past(bo_cnt_q) >= $past(bo_len_q))
        else $error("bulk good changed before filter");
    chk_trip_stop:
        assert property (s_trip |=> !drive_enable_out [*3])
        else $error("drive after trip");
    chk_latch_quiet:
        assert property (st_q == ST_LATCH |=> !drive_enable_out)
        else $error("drive in latched state");
    chk_latch_exit:
        assert property (s_latch_left |-> st_q == ST_RESET &&
                         !$past(f.vcc_rst))
        else $error("latch left without reset level");
    chk_otp_blank:
        assert property (blanking |=> otp_cnt_q == 16'h0000)
        else $error("otp filter ran while blanked");
    chk_boost_start:
        assert property ($rose(mon_q) && blk_len_q != 16'h0000 |=>
                         thermistor_bias_boosted_out)
        else $error("bias not boosted at start");
    chk_bias_bofall:
        assert property (bo_flip && bulk_good_q |=> !mon_q)
        else $error("bias on after brown-out");
    chk_src_kept:
        assert property (st_q == ST_LATCH |-> src_q != 2'b00)
        else $error("trip source lost");

endmodule // bo_ovp_supervisor

//--- sim/ana_model.sv
`timescale 1ns/1ps
module ana_model
#(
    parameter logic [15:0] VCC_ON    = 16'h3a98,
    parameter logic [15:0] VCC_OFF   = 16'h2328,
    parameter logic [15:0] VCC_RST   = 16'h1770,
    parameter logic [15:0] BO_LVL    = 16'h09c4,
    parameter logic [15:0] BO_HYST   = 16'h012c,
    parameter logic [15:0] OVP_LVL   = 16'h0bb8,
    parameter logic [15:0] OTP_LVL   = 16'h01f4,
    parameter logic [15:0] SKIP_IN   = 16'h03e8,
    parameter logic [15:0] SKIP_HYST = 16'h00c8,
    parameter logic [15:0] FB_OFF    = 16'h012c,
    parameter logic [15:0] FB_RES    = 16'h05dc,
    parameter logic [15:0] REM_OFF   = 16'h0fa0,
    parameter logic [15:0] REM_ON    = 16'h03e8
)
(
    // Analogue levels in millivolts
    input  wire logic [15:0] vcc_mv_in,
    input  wire logic [15:0] bulk_mv_in,
    input  wire logic [15:0] prot_mv_in,
    input  wire logic [15:0] fb_mv_in,
    input  wire logic [15:0] rem_mv_in,
    // Controls from the supervisor
    input  wire logic        discharge_in,
    input  wire logic        sink_in,
    input  wire logic        bias_in,
    // Comparator flags
    output logic             vcc_on_out,
    output logic             vcc_off_out,
    output logic             vcc_rst_out,
    output logic             bo_out,
    output logic             ovp_out,
    output logic             otp_out,
    output logic             skip_in_out,
    output logic             skip_out_out,
    output logic             rem_off_out,
    output logic             rem_on_out,
    output logic             fb_off_out,
    output logic             fb_res_out
);
    logic [15:0] sense_mv;
    logic [15:0] pin_mv;

    //==========================================================
    // Bulk divider
    // discharge switch pins sense node low
    assign sense_mv = discharge_in ? 16'h0000 :
                      (sink_in ? bulk_mv_in - BO_HYST : bulk_mv_in);
    assign bo_out = sense_mv > BO_LVL;

    //==========================================================
    // Protection pin, node decays without bias current
    // thermistor node needs the bias source
    assign pin_mv  = bias_in ? prot_mv_in : 16'h0000;
    assign ovp_out = pin_mv > OVP_LVL;
    assign otp_out = pin_mv < OTP_LVL;

    //==========================================================
    // Supply, feedback and remote comparators
    assign vcc_on_out   = vcc_mv_in > VCC_ON;
    assign vcc_off_out  = vcc_mv_in > VCC_OFF;
    assign vcc_rst_out  = vcc_mv_in > VCC_RST;
    assign skip_in_out  = fb_mv_in <= SKIP_IN;
    assign skip_out_out = fb_mv_in > SKIP_IN + SKIP_HYST;
    assign fb_off_out   = fb_mv_in < FB_OFF;
    assign fb_res_out   = fb_mv_in > FB_RES;
    assign rem_off_out  = rem_mv_in > REM_OFF;
    assign rem_on_out   = rem_mv_in < REM_ON;
endmodule // ana_model

//--- sim/tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); end end
`define WAIT(c) \
    for (int w = 0; w < 200 && !(c); w++) begin @(posedge ref_clk); #1; end
module tb;
    import sup_pkg::*;
    logic        ref_clk, arst_n, wr, rd;
    logic [7:0]  addr;
    logic [31:0] wdata, rd_data;
    logic [15:0] vcc, bulk, prot, fb, rem;
    logic        f_on, f_off, f_rst, f_bo, f_ovp, f_otp;
    logic        f_skin, f_skout, f_roff, f_ron, f_fboff, f_fbres;
    logic        irq, sink, dis, bias, boost, mon, bgood, drive;
    int          mismatches, n_checks, cycles;

    //==========================================================
    // Instances
    bo_ovp_supervisor #(.AR_CYCLES(16'h0032)) u_bo_ovp_supervisor (
        .ref_clk_in(ref_clk), .arst_n_in(arst_n),
        .vcc_above_on_in(f_on), .vcc_above_off_in(f_off),
        .vcc_above_reset_in(f_rst), .bo_cmp_in(f_bo),
        .ovp_cmp_in(f_ovp), .otp_cmp_in(f_otp),
        .skip_entry_in(f_skin), .skip_exit_in(f_skout),
        .remote_off_in(f_roff), .remote_on_in(f_ron),
        .fb_offmode_in(f_fboff), .fb_resume_in(f_fbres),
        .addr_in(addr), .wr_data_in(wdata), .wr_in(wr), .rd_in(rd),
        .rd_data_out(rd_data), .irq_out(irq),
        .bulk_hyst_sink_out(sink), .bulk_discharge_out(dis),
        .thermistor_bias_out(bias), .thermistor_bias_boosted_out(boost),
        .prot_monitor_on_out(mon), .bulk_good_out(bgood),
        .drive_enable_out(drive));
    ana_model u_ana_model (
        .vcc_mv_in(vcc), .bulk_mv_in(bulk), .prot_mv_in(prot),
        .fb_mv_in(fb), .rem_mv_in(rem), .discharge_in(dis),
        .sink_in(sink), .bias_in(bias), .vcc_on_out(f_on),
        .vcc_off_out(f_off), .vcc_rst_out(f_rst), .bo_out(f_bo),
        .ovp_out(f_ovp), .otp_out(f_otp), .skip_in_out(f_skin),
        .skip_out_out(f_skout), .rem_off_out(f_roff),
        .rem_on_out(f_ron), .fb_off_out(f_fboff), .fb_res_out(f_fbres));

    //==========================================================
    // Clock, timeout and verdict
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    //==========================================================
    // Register port tasks
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] m,
                           input logic [31:0] exp);
        logic [31:0] d;
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        d = rd_data & m;
        `CHK($sformatf("reg %h", a), exp, d)
    endtask

    //==========================================================
    // Test sequence
    initial
    begin
        arst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00;
        wdata = 32'h0; vcc = 16'h0000; bulk = 16'h03e8;
        prot = 16'h07d0; fb = 16'h07d0; rem = 16'h07d0;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK("discharge", 1'b1, dis)
        `CHK("drive", 1'b0, drive)
        reg_chk(A_CTRL, 32'hffffffff, 32'(CTRL_RST));
        reg_chk(A_MASK, 32'hffffffff, 32'(MASK_RST));
        reg_chk(A_BOLEN, 32'hffffffff, 32'(BO_FILT_CYC));
        reg_chk(A_OVPLEN, 32'hffffffff, 32'(OVP_FILT_CYC));
        reg_chk(A_OTPLEN, 32'hffffffff, 32'(OTP_FILT_CYC));
        reg_chk(A_BLKLEN, 32'hffffffff, 32'(OTP_BLANK_CYC));
        reg_chk(A_ARLEN, 32'hffffffff, 32'h32);
        reg_chk(8'h30, 32'hffffffff, 32'h0);
        reg_wr(A_BOLEN, 32'h4);
        reg_wr(A_OVPLEN, 32'h4);
        reg_wr(A_OTPLEN, 32'h4);
        reg_wr(A_BLKLEN, 32'h14);
        reg_wr(A_MASK, 32'h3f);
        vcc <= 16'h1b58;
        repeat (5) @(posedge ref_clk);
        #1;
        `CHK("discharge", 1'b1, dis)
        vcc <= 16'h3e80;
        `WAIT(!dis)
        `CHK("sink", 1'b1, sink)
        `CHK("monitor", 1'b1, mon)
        @(posedge ref_clk);
        #1;
        `CHK("boost", 1'b1, boost)
        prot <= 16'h0064;
        repeat (12) @(posedge ref_clk);
        prot <= 16'h07d0;
        reg_chk(A_LIVE, 32'h3, 32'h1);
        reg_chk(A_STATUS, 32'h8, 32'h0);
        `WAIT(!boost)
        `CHK("boost", 1'b0, boost)
        $display("test startup done");

        bulk <= 16'h0bb8;
        repeat (3) @(posedge ref_clk);
        bulk <= 16'h03e8;
        repeat (10) @(posedge ref_clk);
        #1;
        `CHK("bulk_good", 1'b0, bgood)
        bulk <= 16'h0bb8;
        `WAIT(bgood)
        `CHK("sink", 1'b0, sink)
        `CHK("drive", 1'b1, drive)
        `CHK("irq", 1'b1, irq)
        reg_chk(A_STATUS, 32'hffffffff, 32'h1);
        reg_wr(A_STATUS, 32'h1);
        reg_chk(A_STATUS, 32'hffffffff, 32'h0);
        `CHK("irq", 1'b0, irq)
        $display("test brownout done");

        prot <= 16'h0fa0;
        repeat (3) @(posedge ref_clk);
        prot <= 16'h07d0;
        repeat (10) @(posedge ref_clk);
        #1;
        `CHK("drive", 1'b1, drive)
        prot <= 16'h0fa0;
        `WAIT(!drive)
        prot <= 16'h07d0;
        reg_chk(A_LIVE, 32'hc3, 32'h42);
        `CHK("bias", 1'b0, bias)
        reg_chk(A_STATUS, 32'h4, 32'h4);
        for (int i = 0; i < 2; i++)
        begin
            vcc <= 16'h1f40;
            repeat (5) @(posedge ref_clk);
            vcc <= 16'h3e80;
            repeat (10) @(posedge ref_clk);
            #1;
            `CHK("drive", 1'b0, drive)
        end
        vcc <= 16'h03e8;
        `WAIT(dis)
        reg_chk(A_LIVE, 32'h3, 32'h0);
        $display("test latch done");

        reg_wr(A_CTRL, 32'h0);
        reg_wr(A_STATUS, 32'h3f);
        vcc <= 16'h3e80;
        `WAIT(!boost)
        `WAIT(drive)
        prot <= 16'h0064;
        `WAIT(!drive)
        prot <= 16'h07d0;
        reg_chk(A_LIVE, 32'hc3, 32'h83);
        `WAIT(mon)
        reg_chk(A_LIVE, 32'h3, 32'h1);
        reg_chk(A_STATUS, 32'h18, 32'h18);
        $display("test autorecovery done");

        `WAIT(!boost)
        fb <= 16'h0384;
        `WAIT(!bias)
        @(posedge ref_clk);
        #1;
        `CHK("drive", 1'b0, drive)
        fb <= 16'h07d0;
        `WAIT(bias)
        `CHK("monitor", 1'b1, mon)
        for (int m = 0; m < 2; m++)
        begin
            reg_wr(A_CTRL, (m == 1) ? 32'h4 : 32'h0);
            reg_wr(A_STATUS, 32'h3f);
            if (m == 1)
                rem <= 16'h1388;
            else
            begin
                fb  <= 16'h00c8;
                vcc <= 16'h1f40;
            end
            `WAIT(!bias)
            reg_chk(A_STATUS, 32'h20, 32'h20);
            `CHK("bias", 1'b0, bias)
            if (m == 1)
                rem <= 16'h01f4;
            else
            begin
                fb  <= 16'h07d0;
                vcc <= 16'h3e80;
            end
            `WAIT(bias)
            `CHK("monitor", 1'b1, mon)
            rem <= 16'h07d0;
        end
        $display("test skip and offmode done");

        bulk <= 16'h03e8;
        `WAIT(!bgood)
        `CHK("bias", 1'b0, bias)
        `CHK("sink", 1'b1, sink)
        reg_chk(A_STATUS, 32'h2, 32'h2);
        $display("test bulk fall done");
        print_verdict();
    end
endmodule // tb
